//--- verilog/tone_test_params.svh
// Purpose: timing counts and tone codes for the tone test mode controller
// Assumes: tone codes are frequencies in whole hertz; one tick per millisecond
// Notes: every duration except the clock and tick periods (ns) is given in ms and turned into ticks by TT_MS_TICKS
`ifndef TONE_TEST_PARAMS_SVH
`define TONE_TEST_PARAMS_SVH

`define TT_CLK_NS 20
`define TT_TICK_NS 1000000
`define TT_TICK_CYCLES (`TT_TICK_NS / `TT_CLK_NS)
`define TT_MS_TICKS(ms) ((ms) * 1000000 / `TT_TICK_NS)

`define TT_REPLY_MS 300000
`define TT_WINDOW_MS 120000
`define TT_LOOP_MS 1200000
`define TT_QUIET_MS 1200000
`define TT_QT_PULSE_MS 1000
`define TT_ID_START_MS 2000
`define TT_ID_LEN_MS 1000
`define TT_CMD_MS 30000
`define TT_REL_MS 900
`define TT_QCMD_MS 5000
`define TT_DWELL_MS 15000
`define TT_SWEEP_MS 3000
`define TT_HOLD_MS 10000

`define TT_RAMP_STEPS 28
`define TT_RAMP_LOW_HZ 12'h13a
`define TT_RAMP_HIGH_HZ 12'hbc6
`define TT_RAMP_STEP_HZ 12'h064

`define TT_F1004 12'h3ec
`define TT_F1014 12'h3f6
`define TT_F2804 12'haf4
`define TT_F2814 12'hafe
`define TT_F404 12'h194
`define TT_F414 12'h19e
`define TT_F1804 12'h70c
`define TT_F1814 12'h716
`define TT_XP_LOW_HZ 12'h130
`define TT_XP_HIGH_HZ 12'hc84
`define TT_XP_OFFSET_HZ 12'h00a

`endif

//--- verilog/tone_test_pkg.sv
// Purpose: state and register types of the tone test mode controller
// Assumes: nothing beyond the params header
// Notes: every module keeps all of its state in one of these structs
package tone_test_pkg;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ACT = 4'h1,
        S_LOOP = 4'h2,
        S_CMD = 4'h3,
        S_AL_2814 = 4'h4,
        S_AL_414 = 4'h5,
        S_AL_WIN = 4'h6,
        S_RAMP = 4'h7,
        S_QT1S = 4'h8,
        S_QUIET = 4'h9,
        S_SWEEP = 4'ha,
        S_XPOND = 4'hb
    } state_t;

    typedef enum logic [1:0] {
        LK_ALIGN = 2'h0,
        LK_TONE = 2'h1,
        LK_MANUAL = 2'h2
    } loop_kind_t;

    typedef struct packed {
        state_t st;
        loop_kind_t kind;
        logic [20:0] tmr;
        logic [15:0] act;
        logic act_prev;
        logic tv_prev;
        logic rel_armed;
        logic ramp_to_qt;
        logic ramp_go;
        logic ramp_up;
        logic commit;
        logic four;
        logic [1:0] sw_idx;
        logic [11:0] xp_code;
        logic gen_on;
        logic [11:0] gen_code;
        logic mlb_s1;
        logic mlb_s2;
        logic lvl_s1;
        logic lvl_s2;
    } ctl_t;

    typedef struct packed {
        logic busy;
        logic up;
        logic done;
        logic [4:0] idx;
        logic [13:0] cnt;
        logic [11:0] code;
    } ramp_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tick_t;

endpackage

//--- verilog/tick_gen.sv
// Purpose: fixed millisecond tick for all controller durations
// Assumes: clk at the rate given by the params header
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "tone_test_params.svh"
module tick_gen #(
    parameter int unsigned CYCLES = `TT_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic tick
);
    tone_test_pkg::tick_t r_q;
    tone_test_pkg::tick_t r_d;

    always_comb
    begin
        r_d = r_q;
        r_d.tick = 1'b0;
        if (r_q.cnt == 16'(CYCLES - 1))
        begin
            r_d.cnt = 16'h0000;
            r_d.tick = 1'b1;
        end
        else
        begin
            r_d.cnt = r_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign tick = r_q.tick;
endmodule
`default_nettype wire

//--- verilog/ramp_sweep.sv
// Purpose: stepped ramp-up or ramp-down result sweep with a final hold
// Assumes: tick is one pulse per millisecond
// Notes: start is ignored while a sweep runs; done pulses once at the end
`timescale 1ns/1ps
`default_nettype none
`include "tone_test_params.svh"
module ramp_sweep #(
    parameter int unsigned STEP_TICKS = `TT_MS_TICKS(`TT_SWEEP_MS) / `TT_RAMP_STEPS,
    parameter int unsigned HOLD_TICKS = `TT_MS_TICKS(`TT_HOLD_MS)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic up,
    output logic busy,
    output logic done,
    output logic [11:0] code
);
    localparam logic [4:0] LAST = 5'(`TT_RAMP_STEPS - 1);

    tone_test_pkg::ramp_t r_q;
    tone_test_pkg::ramp_t r_d;

    function automatic logic [11:0] step_code(input logic dir_up, input logic [4:0] idx);
        logic [11:0] span;
        span = 12'(idx * `TT_RAMP_STEP_HZ);
        step_code = dir_up ? `TT_RAMP_LOW_HZ + span : `TT_RAMP_HIGH_HZ - span;
    endfunction

    always_comb
    begin
        logic [13:0] limit;
        limit = (r_q.idx == LAST) ? 14'(HOLD_TICKS - 1) : 14'(STEP_TICKS - 1);
        r_d = r_q;
        r_d.done = 1'b0;
        if (r_q.busy)
        begin
            if (tick)
            begin
                if (r_q.cnt >= limit)
                begin
                    r_d.cnt = 14'h0000;
                    if (r_q.idx == LAST)
                    begin
                        r_d.busy = 1'b0;
                        r_d.done = 1'b1;
                    end
                    else
                    begin
                        r_d.idx = r_q.idx + 5'h01;
                    end
                end
                else
                begin
                    r_d.cnt = r_q.cnt + 14'h0001;
                end
            end
        end
        else if (start)
        begin
            r_d.busy = 1'b1;
            r_d.up = up;
            r_d.idx = 5'h00;
            r_d.cnt = 14'h0000;
        end
        r_d.code = step_code(r_d.up, r_d.idx);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign busy = r_q.busy;
    assign done = r_q.done;
    assign code = r_q.code;
endmodule
`default_nettype wire

//--- verilog/tone_test_ctrl.sv
// Purpose: mode controller of a four-wire termination answering in-band test tones
// Assumes: detector gives tone_valid/tone_code in hertz on clk; lead pins are async
// Notes: alignment arithmetic lives outside; this block only sequences it
// Operation
// - each alignment reply waits five minutes; expiry gives ramp-down error, idle, no store
// - received 1004 Hz in alignment is answered with 2814 Hz
// - received 2804 Hz is answered with 414 Hz, then wait again
// - received 404 Hz starts 1814 Hz for a 120 second choice window
// - window expiry does three-tone store, result ramp, one second quiet, loopback
// - 1004 Hz in the window ends it early with the three-tone completion
// - 1804 Hz in the window does four-tone store, result ramp, quiet, loopback
// - ramp-up climbs low to high; also sent on twenty minute inactivity
// - ramp-down falls high to low; also sent on five minute inactivity
// - sweep takes about three seconds, last tone held about ten seconds
// - loopback gain is 16 dB at high level setting, else 0 dB
// - alignment loopback ends after 20 min; 0.9 s tone to command, resend idles
// - tone loopback ends after 20 min or on 0.9 s activation tone
// - manual lead loopback ignores timeout and tone, ends when ground removed
// - idle enters loopback on grounded lead or 2 to 30 s activation tone
// - tone loopback entry first sends one second alternating identification tone
// - activation tone beyond thirty seconds enters command mode instead
// - 404 Hz in command mode applies quiet termination and isolates the modem
// - quiet ends idle after 20 silent minutes; 5 s activation tone to command
// - first 404 Hz in quiet sweeps four tones of 15 s, then quiet again
// - other in-band tone starts full-range transponder; activation tone returns command
// - echo offset tone for longer of input or 15 s, then quiet again
`timescale 1ns/1ps
`default_nettype none
`include "tone_test_params.svh"
module tone_test_ctrl #(
    parameter int unsigned TICK_CYCLES = `TT_TICK_CYCLES,
    parameter logic [20:0] REPLY_TICKS = 21'(`TT_MS_TICKS(`TT_REPLY_MS)),
    parameter logic [20:0] WINDOW_TICKS = 21'(`TT_MS_TICKS(`TT_WINDOW_MS)),
    parameter logic [20:0] LOOP_TICKS = 21'(`TT_MS_TICKS(`TT_LOOP_MS)),
    parameter logic [20:0] QUIET_TICKS = 21'(`TT_MS_TICKS(`TT_QUIET_MS)),
    parameter logic [20:0] DWELL_TICKS = 21'(`TT_MS_TICKS(`TT_DWELL_MS)),
    parameter logic [15:0] CMD_TICKS = 16'(`TT_MS_TICKS(`TT_CMD_MS)),
    parameter logic [15:0] QCMD_TICKS = 16'(`TT_MS_TICKS(`TT_QCMD_MS)),
    parameter int unsigned STEP_TICKS = `TT_MS_TICKS(`TT_SWEEP_MS) / `TT_RAMP_STEPS,
    parameter int unsigned HOLD_TICKS = `TT_MS_TICKS(`TT_HOLD_MS)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tone_valid,
    input wire logic [11:0] tone_code,
    input wire logic [11:0] activation_code,
    input wire logic manual_loopback_lead_n,
    input wire logic high_level_sel,
    input wire logic align_within_limits,
    output logic tone_gen_on,
    output logic [11:0] tone_gen_code,
    output logic loopback_on,
    output logic loop_gain_16db,
    output logic quiet_term_on,
    output logic modem_isolate,
    output logic align_commit,
    output logic align_four_tone
);
    localparam logic [20:0] QT_PULSE_TICKS = 21'(`TT_MS_TICKS(`TT_QT_PULSE_MS));
    localparam logic [15:0] ID_START_TICKS = 16'(`TT_MS_TICKS(`TT_ID_START_MS));
    localparam logic [15:0] ID_END_TICKS = 16'(`TT_MS_TICKS(`TT_ID_START_MS + `TT_ID_LEN_MS));
    localparam logic [15:0] REL_TICKS = 16'(`TT_MS_TICKS(`TT_REL_MS));
    localparam logic [15:0] ID_HALF_TICKS = 16'(`TT_MS_TICKS(`TT_ID_LEN_MS) / 4);

    tone_test_pkg::ctl_t c_q;
    tone_test_pkg::ctl_t c_d;
    logic tick;
    logic ramp_busy;
    logic ramp_done;
    logic [11:0] ramp_code;

    // durations all count the shared tick
    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .tick(tick)
    );

    ramp_sweep #(
        .STEP_TICKS(STEP_TICKS),
        .HOLD_TICKS(HOLD_TICKS)
    ) u_ramp (
        .clk(clk),
        .arst_n(arst_n),
        .tick(tick),
        .start(c_q.ramp_go),
        .up(c_q.ramp_up),
        .busy(ramp_busy),
        .done(ramp_done),
        .code(ramp_code)
    );

    function automatic logic heard(input logic valid, input logic [11:0] code,
                                   input logic [11:0] want);
        heard = valid && (code == want);
    endfunction

    always_comb
    begin
        tone_test_pkg::state_t nxt;
        logic act_on;
        logic act_edge;
        logic new_tone;
        logic in_band;
        nxt = c_q.st;
        c_d = c_q;
        c_d.commit = 1'b0;
        c_d.ramp_go = 1'b0;
        // pins pass two flops before anything reads them
        c_d.mlb_s1 = manual_loopback_lead_n;
        c_d.mlb_s2 = c_q.mlb_s1;
        c_d.lvl_s1 = high_level_sel;
        c_d.lvl_s2 = c_q.lvl_s1;
        c_d.tv_prev = tone_valid;
        act_on = heard(tone_valid, tone_code, activation_code);
        c_d.act_prev = act_on;
        act_edge = act_on && !c_q.act_prev;
        new_tone = tone_valid && (!c_q.tv_prev || tone_code != c_q.xp_code);
        in_band = tone_valid && tone_code >= `TT_XP_LOW_HZ && tone_code <= `TT_XP_HIGH_HZ;
        if (!act_on)
            c_d.act = 16'h0000;
        else if (tick && c_q.act != 16'hffff)
            c_d.act = c_q.act + 16'h0001;
        if (tick && c_q.tmr != 21'h1fffff)
            c_d.tmr = c_q.tmr + 21'h000001;

        unique case (c_q.st)
            tone_test_pkg::S_IDLE:
            begin
                if (!c_q.mlb_s2)
                begin
                    nxt = tone_test_pkg::S_LOOP;
                    c_d.kind = tone_test_pkg::LK_MANUAL;
                end
                else if (act_on)
                    nxt = tone_test_pkg::S_ACT;
            end
            tone_test_pkg::S_ACT:
            begin
                if (c_q.act >= CMD_TICKS)
                begin
                    nxt = tone_test_pkg::S_CMD;
                    c_d.rel_armed = 1'b0;
                end
                else if (!act_on)
                begin
                    // a short burst is not a command; past the id start it loops, else back to idle quietly
                    if (c_q.tmr > 21'(ID_START_TICKS))
                    begin
                        nxt = tone_test_pkg::S_LOOP;
                        c_d.kind = tone_test_pkg::LK_TONE;
                    end
                    else
                        nxt = tone_test_pkg::S_IDLE;
                end
            end
            tone_test_pkg::S_LOOP:
            begin
                if (c_q.kind == tone_test_pkg::LK_MANUAL)
                begin
                    if (c_q.mlb_s2)
                        nxt = tone_test_pkg::S_IDLE;
                end
                else if (c_q.tmr >= LOOP_TICKS)
                begin
                    nxt = tone_test_pkg::S_RAMP;
                    c_d.ramp_go = 1'b1;
                    c_d.ramp_up = 1'b1;
                    c_d.ramp_to_qt = 1'b0;
                end
                else if (c_q.act >= REL_TICKS)
                begin
                    if (c_q.kind == tone_test_pkg::LK_ALIGN)
                    begin
                        nxt = tone_test_pkg::S_CMD;
                        c_d.rel_armed = 1'b1;
                    end
                    else
                        nxt = tone_test_pkg::S_IDLE;
                end
            end
            tone_test_pkg::S_CMD:
            begin
                if (c_q.rel_armed && act_edge)
                    nxt = tone_test_pkg::S_IDLE;
                else if (heard(tone_valid, tone_code, `TT_F1004))
                    nxt = tone_test_pkg::S_AL_2814;
                else if (heard(tone_valid, tone_code, `TT_F404))
                    nxt = tone_test_pkg::S_QUIET;
                else if (c_q.tmr >= REPLY_TICKS)
                begin
                    nxt = tone_test_pkg::S_RAMP;
                    c_d.ramp_go = 1'b1;
                    c_d.ramp_up = 1'b0;
                    c_d.ramp_to_qt = 1'b0;
                end
            end
            tone_test_pkg::S_AL_2814, tone_test_pkg::S_AL_414:
            begin
                if (c_q.st == tone_test_pkg::S_AL_2814 &&
                    heard(tone_valid, tone_code, `TT_F2804))
                    nxt = tone_test_pkg::S_AL_414;
                else if (c_q.st == tone_test_pkg::S_AL_414 &&
                         heard(tone_valid, tone_code, `TT_F404))
                    nxt = tone_test_pkg::S_AL_WIN;
                else if (c_q.tmr >= REPLY_TICKS)
                begin
                    // no commit on this path, so stored values stay as they were
                    nxt = tone_test_pkg::S_RAMP;
                    c_d.ramp_go = 1'b1;
                    c_d.ramp_up = 1'b0;
                    c_d.ramp_to_qt = 1'b0;
                end
            end
            tone_test_pkg::S_AL_WIN:
            begin
                if (heard(tone_valid, tone_code, `TT_F1804) ||
                    heard(tone_valid, tone_code, `TT_F1004) || c_q.tmr >= WINDOW_TICKS)
                begin
                    c_d.four = heard(tone_valid, tone_code, `TT_F1804);
                    c_d.commit = 1'b1;
                    c_d.ramp_go = 1'b1;
                    c_d.ramp_up = align_within_limits;
                    c_d.ramp_to_qt = 1'b1;
                    nxt = tone_test_pkg::S_RAMP;
                end
            end
            tone_test_pkg::S_RAMP:
            begin
                if (ramp_done)
                    nxt = c_q.ramp_to_qt ? tone_test_pkg::S_QT1S : tone_test_pkg::S_IDLE;
            end
            tone_test_pkg::S_QT1S:
            begin
                if (c_q.tmr >= QT_PULSE_TICKS)
                begin
                    nxt = tone_test_pkg::S_LOOP;
                    c_d.kind = tone_test_pkg::LK_ALIGN;
                end
            end
            tone_test_pkg::S_QUIET:
            begin
                if (c_q.act >= QCMD_TICKS)
                begin
                    nxt = tone_test_pkg::S_CMD;
                    c_d.rel_armed = 1'b0;
                end
                else if (heard(tone_valid && !c_q.tv_prev, tone_code, `TT_F404))
                begin
                    nxt = tone_test_pkg::S_SWEEP;
                    c_d.sw_idx = 2'h0;
                end
                else if (in_band && !act_on && !c_q.tv_prev)
                begin
                    nxt = tone_test_pkg::S_XPOND;
                    c_d.xp_code = tone_code;
                end
                else if (c_q.tmr >= QUIET_TICKS)
                begin
                    nxt = tone_test_pkg::S_RAMP;
                    c_d.ramp_go = 1'b1;
                    c_d.ramp_up = 1'b1;
                    c_d.ramp_to_qt = 1'b0;
                end
            end
            tone_test_pkg::S_SWEEP:
            begin
                if (c_q.tmr >= DWELL_TICKS)
                begin
                    c_d.tmr = 21'h000000;
                    c_d.sw_idx = c_q.sw_idx + 2'h1;
                    if (c_q.sw_idx == 2'h3)
                        nxt = tone_test_pkg::S_QUIET;
                end
            end
            tone_test_pkg::S_XPOND:
            begin
                if (c_q.act >= QCMD_TICKS)
                begin
                    nxt = tone_test_pkg::S_CMD;
                    c_d.rel_armed = 1'b0;
                end
                else if (new_tone && in_band && !act_on)
                begin
                    c_d.xp_code = tone_code;
                    c_d.tmr = 21'h000000;
                end
                else if (!tone_valid && c_q.tmr >= DWELL_TICKS)
                    nxt = tone_test_pkg::S_QUIET;
            end
            default:
                nxt = tone_test_pkg::S_IDLE;
        endcase

        if (nxt != c_q.st)
            c_d.tmr = 21'h000000;
        c_d.st = nxt;

        c_d.gen_on = 1'b1;
        unique case (c_q.st)
            tone_test_pkg::S_CMD:
                c_d.gen_code = `TT_F1014;
            tone_test_pkg::S_AL_2814:
                c_d.gen_code = `TT_F2814;
            tone_test_pkg::S_AL_414:
                c_d.gen_code = `TT_F414;
            tone_test_pkg::S_AL_WIN:
                c_d.gen_code = `TT_F1814;
            tone_test_pkg::S_ACT:
            begin
                // alternate the two id tones every quarter second
                c_d.gen_on = c_q.act > ID_START_TICKS && c_q.act <= ID_END_TICKS;
                c_d.gen_code = (((c_q.act - ID_START_TICKS) / ID_HALF_TICKS) & 16'h0001) != 0
                    && c_d.gen_on ? `TT_F1814 : (c_d.gen_on ? `TT_F2814 : 12'h000);
            end
            tone_test_pkg::S_SWEEP:
            begin
                unique case (c_q.sw_idx)
                    2'h0: c_d.gen_code = `TT_F414;
                    2'h1: c_d.gen_code = `TT_F1014;
                    2'h2: c_d.gen_code = `TT_F1814;
                    2'h3: c_d.gen_code = `TT_F2814;
                endcase
            end
            tone_test_pkg::S_XPOND:
                c_d.gen_code = c_q.xp_code + `TT_XP_OFFSET_HZ;
            tone_test_pkg::S_RAMP:
            begin
                c_d.gen_on = ramp_busy;
                c_d.gen_code = ramp_busy ? ramp_code : 12'h000;
            end
            default:
            begin
                c_d.gen_on = 1'b0;
                c_d.gen_code = 12'h000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            c_q <= '0;
            c_q.mlb_s1 <= 1'b1;
            c_q.mlb_s2 <= 1'b1;
        end
        else
            c_q <= c_d;
    end

    assign tone_gen_on = c_q.gen_on;
    assign tone_gen_code = c_q.gen_code;
    assign loopback_on = c_q.st == tone_test_pkg::S_LOOP;
    assign loop_gain_16db = loopback_on && c_q.lvl_s2;
    // quiet termination and modem isolation hold through every transponder state
    assign quiet_term_on = c_q.st == tone_test_pkg::S_QUIET ||
        c_q.st == tone_test_pkg::S_SWEEP || c_q.st == tone_test_pkg::S_XPOND ||
        c_q.st == tone_test_pkg::S_QT1S;
    assign modem_isolate = quiet_term_on;
    assign align_commit = c_q.commit;
    assign align_four_tone = c_q.four;
endmodule
`default_nettype wire

//--- tb/tone_test_ctrl_assertions.sv
// Purpose: port checks for the tone controller
// Assumes: align_within_limits held steady around a commit
// Notes: bind at the foot
`timescale 1ns/1ps
`default_nettype none
module tone_test_ctrl_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic align_within_limits,
    input wire logic tone_gen_on,
    input wire logic [11:0] tone_gen_code,
    input wire logic loopback_on,
    input wire logic loop_gain_16db,
    input wire logic quiet_term_on,
    input wire logic modem_isolate,
    input wire logic align_commit,
    input wire logic align_four_tone
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence ramp_start;
        ##[1:4] tone_gen_code == (align_within_limits ? 12'h13a : 12'hbc6);
    endsequence
    a_gain_in_loop: assert property (loop_gain_16db |-> loopback_on)
        else $error("gain off loop");
    a_isolate_quiet: assert property (modem_isolate == quiet_term_on)
        else $error("isolate mismatch");
    a_loop_not_quiet: assert property (!(loopback_on && quiet_term_on))
        else $error("loop and quiet");
    a_gen_off_zero: assert property (!tone_gen_on |-> tone_gen_code == 12'h000)
        else $error("code while off");
    a_commit_pulse: assert property (align_commit |=> !align_commit)
        else $error("long commit");
    a_commit_window: assert property (align_commit |-> tone_gen_code == 12'h716)
        else $error("commit off window");
    a_commit_ramp: assert property (align_commit |-> ramp_start)
        else $error("wrong sweep");
    a_four_on_commit: assert property ($changed(align_four_tone) |-> align_commit)
        else $error("count changed");
endmodule
bind tone_test_ctrl tone_test_ctrl_chk chk (.clk(clk), .arst_n(arst_n),
    .align_within_limits(align_within_limits), .tone_gen_on(tone_gen_on),
    .tone_gen_code(tone_gen_code), .loopback_on(loopback_on), .loop_gain_16db(loop_gain_16db),
    .quiet_term_on(quiet_term_on), .modem_isolate(modem_isolate),
    .align_commit(align_commit), .align_four_tone(align_four_tone));
`default_nettype wire

//--- tb/remote_test_set.sv
// Purpose: far-end test set sending tones
// Assumes: code read only while valid
// Notes: one tone at a time
`timescale 1ns/1ps
`default_nettype none
module remote_test_set (
    input wire logic clk,
    output logic tone_valid,
    output logic [11:0] tone_code
);
    logic [11:0] held;
    logic [11:0] idle_pat = 12'h5a5;
    initial tone_valid = 1'b0;
    // code wanders when idle so a stale tone is never read as live
    always @(posedge clk) idle_pat <= idle_pat + 12'h3b7;
    assign tone_code = tone_valid ? held : idle_pat;
    task automatic tone_on(input logic [11:0] c);
        @(posedge clk);
        held <= c;
        tone_valid <= 1'b1;
    endtask
    task automatic tone_off();
        @(posedge clk);
        tone_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb/tone_test_ctrl_tb.sv
// Purpose: self-checking bench for the tone controller
// Assumes: four clocks per tick, short counts
// Notes: tones from remote_test_set
`timescale 1ns/1ps
`default_nettype none
`include "tone_test_params.svh"
module tone_test_ctrl_tb;
    localparam logic [11:0] ACT = 12'ha99;
    logic clk, arst_n, lead_n, hl, awl, tone_valid, gen_on, loop_on, gain, quiet, iso;
    logic commit, four;
    logic [11:0] tone_code, gen_code;
    int errors, comparisons, seed;
    always #10 clk = ~clk;
    remote_test_set far (.clk(clk), .tone_valid(tone_valid), .tone_code(tone_code));
    tone_test_ctrl #(.TICK_CYCLES(4), .CMD_TICKS(16'd3500), .STEP_TICKS(2), .HOLD_TICKS(5),
        .REPLY_TICKS(21'h000032), .DWELL_TICKS(21'h00000a), .QCMD_TICKS(16'h0014)) dut (
        .clk(clk), .arst_n(arst_n), .tone_valid(tone_valid), .tone_code(tone_code),
        .activation_code(ACT), .manual_loopback_lead_n(lead_n), .high_level_sel(hl),
        .align_within_limits(awl), .tone_gen_on(gen_on), .tone_gen_code(gen_code),
        .loopback_on(loop_on), .loop_gain_16db(gain), .quiet_term_on(quiet),
        .modem_isolate(iso), .align_commit(commit), .align_four_tone(four));
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // sel 0 generator code, 1 loopback, 2 quiet
    task automatic wait_for(input int sel, input logic [11:0] want, input int lim);
        logic [11:0] v;
        for (int i = 0; i < lim; i++)
        begin
            @(negedge clk);
            v = (sel == 0) ? gen_code : {11'h000, (sel == 1) ? loop_on : quiet};
            if (v === want)
                break;
        end
        check(v, want);
        if (v !== want)
            stop_test();
    endtask
    task automatic align(input logic [11:0] last);
        logic [11:0] tx[$];
        logic [11:0] rx[$];
        tx = '{ACT, `TT_F1004, `TT_F2804, `TT_F404, last};
        rx = '{`TT_F1014, `TT_F2814, `TT_F414, `TT_F1814,
            awl ? `TT_RAMP_LOW_HZ : `TT_RAMP_HIGH_HZ};
        foreach (tx[i])
        begin
            far.tone_on(tx[i]);
            wait_for(0, rx[i], 15000);
            far.tone_off();
        end
        check({11'h000, four}, {11'h000, last == `TT_F1804});
        wait_for(2, 12'h001, 400);
        wait_for(1, 12'h001, 4400);
    endtask
    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        lead_n = 1'b1;
        errors = 0;
        comparisons = 0;
        seed = 39;
        hl = 1'($random(seed));
        awl = 1'($random(seed));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check(12'({loop_on, quiet, gen_on, commit}), 12'h000);
        @(posedge clk);
        lead_n <= 1'b0;
        wait_for(1, 12'h001, 10);
        check({11'h000, gain}, {11'h000, hl});
        far.tone_on(ACT);
        repeat (4000) @(posedge clk);
        check({11'h000, loop_on}, 12'h001);
        far.tone_off();
        lead_n <= 1'b1;
        wait_for(1, 12'h000, 10);
        far.tone_on(ACT);
        wait_for(0, `TT_F1814, 9600);
        far.tone_off();
        wait_for(1, 12'h001, 4400);
        far.tone_on(ACT);
        wait_for(1, 12'h000, 4000);
        far.tone_off();
        repeat (20) @(posedge clk);
        align(`TT_F1804);
        far.tone_on(ACT);
        wait_for(0, `TT_F1014, 4000);
        far.tone_off();
        far.tone_on(ACT);
        wait_for(0, 12'h000, 20);
        far.tone_off();
        repeat (20) @(posedge clk);
        awl <= ~awl;
        align(`TT_F1004);
        far.tone_on(ACT);
        wait_for(0, `TT_F1014, 4000);
        far.tone_off();
        far.tone_on(`TT_F404);
        wait_for(2, 12'h001, 10);
        check({11'h000, iso}, 12'h001);
        far.tone_off();
        far.tone_on(`TT_F404);
        wait_for(0, `TT_F414, 10);
        far.tone_off();
        wait_for(0, 12'h000, 300);
        far.tone_on(12'h3e8);
        wait_for(0, 12'h3e8 + `TT_XP_OFFSET_HZ, 10);
        far.tone_off();
        wait_for(0, 12'h000, 100);
        far.tone_on(ACT);
        wait_for(0, `TT_F1014, 200);
        far.tone_off();
        wait_for(0, `TT_RAMP_HIGH_HZ, 300);
        wait_for(0, 12'h000, 300);
        check({11'h000, quiet}, 12'h000);
        stop_test();
    end
endmodule
`default_nettype wire
